// ### inc/flp_pkg.sv
// Shared constants, types and decode functions for the flash status and protection block.
package flp_pkg;
    // Clock and timing.
    localparam int CLK_MHZ = 25;
    localparam int SR_WRITE_NS = 1000;
    localparam logic [15:0] SR_WRITE_CNT = 16'((SR_WRITE_NS * CLK_MHZ + 999) / 1000);

    // Command codes.
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_RD_SR0 = 8'h05;
    localparam logic [7:0] OP_RD_SR1 = 8'h35;
    localparam logic [7:0] OP_RD_SR2 = 8'h15;
    localparam logic [7:0] OP_WR_SR0 = 8'h01;
    localparam logic [7:0] OP_WR_SR1 = 8'h31;
    localparam logic [7:0] OP_WR_SR2 = 8'h11;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SECT = 8'h20;
    localparam logic [7:0] OP_BLK = 8'hd8;
    localparam logic [7:0] OP_CHIP_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_B = 8'h60;
    localparam logic [7:0] OP_LOCK = 8'h36;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_RD_LOCK = 8'h3d;
    localparam logic [7:0] OP_LOCK_ALL = 8'h7e;
    localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;

    // Status bit positions.
    localparam int B_WIP = 0;
    localparam int B_WEL = 1;
    localparam int B_BP = 2;
    localparam int B_GLO = 7;
    localparam int B_GHI = 8;
    localparam int B_QE = 9;
    localparam int B_PROGRAM_SUSPENDED_FLAG = 10;
    localparam int B_LK = 11;
    localparam int B_CMP = 14;
    localparam int B_ERASE_SUSPENDED_FLAG = 15;
    localparam int B_WPS = 18;
    localparam int B_DRV = 21;
    localparam int B_PFS = 23;
    localparam logic [1:0] DRV_RST = 2'h2;

    // Lock array and address geometry.
    localparam int LOCK_UNITS = 286;
    localparam logic [8:0] EDGE_UNITS = 9'h020;
    localparam logic [8:0] MID_BASE = 9'h01f;
    localparam logic [23:0] PAGE_MASK = 24'h0000ff;
    localparam logic [23:0] SECT_MASK = 24'h000fff;
    localparam logic [23:0] BLK_MASK = 24'h00ffff;

    typedef enum logic [1:0] {ARR_PROG, ARR_SECT, ARR_BLK, ARR_CHIP} flp_arr_t;
    typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_LREAD, ST_SR, ST_ARR} flp_state_t;

    typedef struct packed {
        flp_state_t state;
        logic write_in_progress;
        logic write_enable_latch;
        logic [4:0] bp;
        logic glo;
        logic ghi;
        logic qe;
        logic cmp;
        logic protect_scheme_select;
        logic pfs;
        logic [2:0] lk;
        logic [1:0] drv;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic [15:0] cnt;
        logic [23:0] addr;
        flp_arr_t op;
        logic [23:0] status;
        logic [7:0] rd_data;
        logic rd_valid;
        logic go;
        logic reject;
        logic ready;
    } flp_st_t;

    typedef struct packed {
        logic [LOCK_UNITS-1:0] bits;
        logic rd;
        logic grp;
        logic any;
    } flp_mem_t;

    // Maps an address to its lock unit: edge-block sectors first, then middle blocks.
    function automatic logic [8:0] unit_index(input logic [23:0] a);
        if (a[23:16] == 8'h00) begin
            return {5'h00, a[15:12]};
        end
        if (a[23:16] == 8'hff) begin
            return {5'h01, a[15:12]};
        end
        return {1'b0, a[23:16]} + MID_BASE;
    endfunction : unit_index

    // True when the address falls in the region chosen by the level bits and invert bit.
    function automatic logic bp_hit(input logic [23:0] a, input logic [4:0] bp, input logic cmp);
        logic [2:0] n;
        logic [24:0] sz;
        logic hit;
        n = bp[2:0];
        sz = bp[4] ? (25'h0000800 << ((n > 3'h4) ? 3'h4 : n)) : (25'h0020000 << n);
        if (n == 3'h0) begin
            hit = 1'b0;
        end else if (n == 3'h7) begin
            hit = 1'b1;
        end else if (!bp[3]) begin
            hit = {1'b0, a} >= (25'h1000000 - sz);
        end else begin
            hit = {1'b0, a} < sz;
        end
        return hit ^ cmp;
    endfunction : bp_hit

    // Packs the status word; reserved positions stay zero.
    function automatic logic [23:0] status_word(input flp_st_t s);
        logic [23:0] w;
        w = 24'h000000;
        w[B_WIP] = s.write_in_progress;
        w[B_WEL] = s.write_enable_latch;
        w[B_BP+:5] = s.bp;
        w[B_GLO] = s.glo;
        w[B_GHI] = s.ghi;
        w[B_QE] = s.qe;
        w[B_PROGRAM_SUSPENDED_FLAG] = s.program_suspended_flag;
        w[B_LK+:3] = s.lk;
        w[B_CMP] = s.cmp;
        w[B_ERASE_SUSPENDED_FLAG] = s.erase_suspended_flag;
        w[B_WPS] = s.protect_scheme_select;
        w[B_DRV+:2] = s.drv;
        w[B_PFS] = s.pfs;
        return w;
    endfunction : status_word
endpackage : flp_pkg

// ### hw/flp_lock_mem.sv
// Individual lock bit store with registered read, group and global summaries.
`timescale 1ns/1ps
module flp_lock_mem
    import flp_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic wr_en_in,
    input wire logic wr_val_in,
    input wire logic [8:0] wr_idx_in,
    input wire logic all_en_in,
    input wire logic all_val_in,
    input wire logic [8:0] rd_idx_in,
    output logic rd_bit_out,
    output logic grp_out,
    output logic any_out
);
    flp_mem_t m_r;
    flp_mem_t m_nxt;

    always_comb begin
        m_nxt = m_r;
        if (all_en_in) begin
            m_nxt.bits = {LOCK_UNITS{all_val_in}};
        end else if (wr_en_in) begin
            m_nxt.bits[wr_idx_in] = wr_val_in;
        end
        // Reads see this cycle's write so a check right after a lock command is not stale.
        m_nxt.rd = m_nxt.bits[rd_idx_in];
        m_nxt.grp = (rd_idx_in < EDGE_UNITS) && (|m_nxt.bits[{rd_idx_in[4], 4'h0}+:16]);
        m_nxt.any = |m_nxt.bits;
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            m_r <= '{bits: {LOCK_UNITS{1'b1}}, rd: 1'b1, grp: 1'b1, any: 1'b1};
        end else begin
            m_r <= m_nxt;
        end
    end

    assign rd_bit_out = m_r.rd;
    assign grp_out = m_r.grp;
    assign any_out = m_r.any;
endmodule : flp_lock_mem

// ### hw/flp_status_guard.sv
// Status register, write-protection policy and lock command handling of the flash.
`timescale 1ns/1ps
// Function
// - Busy bit is high during program, erase or status write, else low.
// - With the enable latch clear, status writes, programs and erases are refused.
// - Five level bits, written only by status write, select a protected array region.
// - Level bits change only when hardware status protection is not in force.
// - Chip erase runs only with low three level bits and invert bit all zero; with scheme select 1 it needs every individual lock clear instead.
// - Invert with level 00001 protects 000000 to FBFFFF.
// - Invert with level 01001 protects 040000 to FFFFFF.
// - Invert with level 10001 protects all but the top 4KB sector.
// - Invert with level 11001 protects all but the bottom 4KB sector.
// - Separate locks for 32 edge-block sectors and the 254 other blocks.
// - Commands 36, 39, 3D lock, unlock and read the addressed unit.
// - Command 7E sets every individual lock bit.
// - Command 98 clears every individual lock bit.
// - The 24 status bits sit at their fixed positions.
// - Guard 00 accepts status writes whenever the enable latch is set.
// - Guard 01 locks status while the protect pin is low.
// - Guard 10 refuses status writes until power cycle, which returns 00.
// - Guard 11 refuses status writes permanently; here reset returns it to 00 as for guard 10.
// - Quad enable defaults 0; at 1 protect pin function is dropped.
// - Secure area locks are one-time settable, each bit individually; here reset clears them to 000.
// - Invert bit is read/write, default 0, and inverts the level region.
// - Scheme select 0 uses level bits, 1 uses individual locks.
// - All individual locks are set at reset.
// - Enable latch clears at reset, write disable, status write, program, erase.
module flp_status_guard
    import flp_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [23:0] cmd_addr_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic write_protect_pin_in,
    input wire logic array_done_in,
    input wire logic erase_suspended_in,
    input wire logic program_suspended_in,
    output logic [23:0] status_out,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic reject_out,
    output logic array_go_out,
    output flp_arr_t array_op_out,
    output logic [23:0] array_addr_out,
    output logic cmd_ready_out,
    output logic quad_mode_out,
    output logic [1:0] drive_strength_out,
    output logic pin_function_out
);
    flp_st_t st_r;
    flp_st_t st_nxt;
    logic lk_wr;
    logic lk_val;
    logic lk_all;
    logic lk_all_val;
    logic lk_bit;
    logic lk_grp;
    logic lk_any;
    logic sr_ok;
    logic locked;
    logic is_rd_sr;
    logic is_wr_sr;
    logic is_array;
    logic is_chip;
    logic [23:0] mask;

    flp_lock_mem u_lock (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .wr_en_in(lk_wr),
        .wr_val_in(lk_val),
        .wr_idx_in(unit_index(cmd_addr_in)),
        .all_en_in(lk_all),
        .all_val_in(lk_all_val),
        .rd_idx_in(unit_index(cmd_addr_in)),
        .rd_bit_out(lk_bit),
        .grp_out(lk_grp),
        .any_out(lk_any)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.go = 1'b0;
        st_nxt.reject = 1'b0;
        st_nxt.erase_suspended_flag = erase_suspended_in;
        st_nxt.program_suspended_flag = program_suspended_in;
        lk_wr = 1'b0;
        lk_val = 1'b0;
        lk_all = 1'b0;
        lk_all_val = 1'b0;
        is_rd_sr = cmd_code_in inside {OP_RD_SR0, OP_RD_SR1, OP_RD_SR2};
        is_wr_sr = cmd_code_in inside {OP_WR_SR0, OP_WR_SR1, OP_WR_SR2};
        is_array = cmd_code_in inside {OP_PROG, OP_SECT, OP_BLK};
        is_chip = cmd_code_in inside {OP_CHIP_A, OP_CHIP_B};
        // guard modes
        // The protect pin only counts while it is not a data line.
        sr_ok = !st_r.ghi && (!st_r.glo || write_protect_pin_in || st_r.qe);
        mask = (st_r.op == ARR_PROG) ? PAGE_MASK : (st_r.op == ARR_SECT) ? SECT_MASK : BLK_MASK;
        if (st_r.protect_scheme_select) begin
            locked = (st_r.op == ARR_BLK && (st_r.addr[23:16] == 8'h00 || st_r.addr[23:16] == 8'hff))
                ? lk_grp : lk_bit;
        end else begin
            locked = bp_hit(st_r.addr & ~mask, st_r.bp, st_r.cmp)
                | bp_hit(st_r.addr | mask, st_r.bp, st_r.cmp);
        end
        if (cmd_valid_in && is_rd_sr) begin
            // Status reads are served in every state but ST_LREAD, where the lock bit takes rd_data, so the host can poll the busy bit.
            unique case (cmd_code_in)
                OP_RD_SR0: st_nxt.rd_data = st_r.status[7:0];
                OP_RD_SR1: st_nxt.rd_data = st_r.status[15:8];
                default: st_nxt.rd_data = st_r.status[23:16];
            endcase
            st_nxt.rd_valid = 1'b1;
        end else if (cmd_valid_in && st_r.state != ST_IDLE) begin
            st_nxt.reject = 1'b1;
        end
        unique case (st_r.state)
            ST_IDLE: begin
                if (cmd_valid_in && !is_rd_sr) begin
                    if (cmd_code_in == OP_WR_EN) begin
                        st_nxt.write_enable_latch = 1'b1;
                    end else if (cmd_code_in == OP_WR_DIS) begin
                        st_nxt.write_enable_latch = 1'b0;
                    end else if ((is_wr_sr || is_array || is_chip) && !st_r.write_enable_latch) begin
                        st_nxt.reject = 1'b1;
                    end else if (is_wr_sr) begin
                        st_nxt.write_enable_latch = 1'b0;
                        if (!sr_ok) begin
                            st_nxt.reject = 1'b1;
                        end else begin
                            unique case (cmd_code_in)
                                OP_WR_SR0: begin
                                    st_nxt.glo = cmd_data_in[B_GLO];
                                    st_nxt.bp = cmd_data_in[B_BP+:5];
                                end
                                OP_WR_SR1: begin
                                    st_nxt.cmp = cmd_data_in[B_CMP-8];
                                    st_nxt.lk = st_r.lk | cmd_data_in[B_LK-8+:3];
                                    st_nxt.qe = cmd_data_in[B_QE-8];
                                    st_nxt.ghi = cmd_data_in[B_GHI-8];
                                end
                                default: begin
                                    st_nxt.pfs = cmd_data_in[B_PFS-16];
                                    st_nxt.drv = cmd_data_in[B_DRV-16+:2];
                                    st_nxt.protect_scheme_select = cmd_data_in[B_WPS-16];
                                end
                            endcase
                            st_nxt.write_in_progress = 1'b1;
                            st_nxt.cnt = SR_WRITE_CNT;
                            st_nxt.state = ST_SR;
                        end
                    end else if (is_array) begin
                        st_nxt.addr = cmd_addr_in;
                        st_nxt.op = (cmd_code_in == OP_PROG) ? ARR_PROG
                            : (cmd_code_in == OP_SECT) ? ARR_SECT : ARR_BLK;
                        st_nxt.state = ST_CHECK;
                    end else if (is_chip) begin
                        st_nxt.write_enable_latch = 1'b0;
                        if (st_r.protect_scheme_select ? lk_any : (st_r.bp[2:0] != 3'h0 || st_r.cmp)) begin
                            st_nxt.reject = 1'b1;
                        end else begin
                            st_nxt.op = ARR_CHIP;
                            st_nxt.addr = 24'h000000;
                            st_nxt.go = 1'b1;
                            st_nxt.write_in_progress = 1'b1;
                            st_nxt.state = ST_ARR;
                        end
                    end else if (cmd_code_in == OP_LOCK || cmd_code_in == OP_UNLOCK) begin
                        lk_wr = 1'b1;
                        lk_val = (cmd_code_in == OP_LOCK);
                    end else if (cmd_code_in == OP_RD_LOCK) begin
                        st_nxt.state = ST_LREAD;
                    end else if (cmd_code_in == OP_LOCK_ALL || cmd_code_in == OP_UNLOCK_ALL) begin
                        lk_all = 1'b1;
                        lk_all_val = (cmd_code_in == OP_LOCK_ALL);
                    end
                end
            end
            ST_CHECK: begin
                st_nxt.write_enable_latch = 1'b0;
                st_nxt.state = locked ? ST_IDLE : ST_ARR;
                st_nxt.reject = st_nxt.reject | locked;
                st_nxt.go = !locked;
                st_nxt.write_in_progress = !locked;
            end
            ST_LREAD: begin
                st_nxt.rd_data = {7'h00, lk_bit};
                st_nxt.rd_valid = 1'b1;
                st_nxt.state = ST_IDLE;
            end
            ST_SR: begin
                st_nxt.cnt = st_r.cnt - 16'h0001;
                if (st_r.cnt == 16'h0001) begin
                    st_nxt.write_in_progress = 1'b0;
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_ARR: begin
                if (array_done_in) begin
                    st_nxt.write_in_progress = 1'b0;
                    st_nxt.state = ST_IDLE;
                end
            end
        endcase
        st_nxt.ready = (st_nxt.state == ST_IDLE);
        st_nxt.status = status_word(st_nxt);
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_r <= '{state: ST_IDLE, drv: DRV_RST, status: 24'h400000, ready: 1'b1,
                op: ARR_PROG, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign status_out = st_r.status;
    assign rd_data_out = st_r.rd_data;
    assign rd_valid_out = st_r.rd_valid;
    assign reject_out = st_r.reject;
    assign array_go_out = st_r.go;
    assign array_op_out = st_r.op;
    assign array_addr_out = st_r.addr;
    assign cmd_ready_out = st_r.ready;
    assign quad_mode_out = st_r.qe;
    assign drive_strength_out = st_r.drv;
    assign pin_function_out = st_r.pfs;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    AST_WIP_BUSY: assert property (
        st_r.state == ST_ARR && !array_done_in |=> status_out[B_WIP])
        else $error("busy bit dropped before array done");
    AST_WEL_GATE: assert property (
        cmd_valid_in && cmd_ready_out && is_wr_sr && !status_out[B_WEL]
        |=> reject_out && $stable(status_out[23:2]))
        else $error("status write taken without enable latch");
    AST_HW_LOCK: assert property (
        cmd_valid_in && cmd_ready_out && is_wr_sr && status_out[B_WEL] && !status_out[B_GHI]
        && status_out[B_GLO] && !write_protect_pin_in && !status_out[B_QE]
        |=> reject_out && $stable(status_out[B_BP+:5]))
        else $error("status write taken while pin locked");
    AST_GUARD_HI: assert property (
        cmd_valid_in && cmd_ready_out && is_wr_sr && status_out[B_GHI]
        |=> reject_out && !status_out[B_WIP])
        else $error("status write taken under guard");
    AST_CHIP_GATE: assert property (
        array_go_out && array_op_out == ARR_CHIP && !status_out[B_WPS]
        |-> $past(status_out[B_BP+:3]) == 3'h0 && !$past(status_out[B_CMP]))
        else $error("chip erase started while protected");
    AST_INV_TOP: assert property (
        st_r.state == ST_CHECK && !st_r.protect_scheme_select && st_r.cmp && st_r.bp == 5'h01
        && st_r.addr < 24'hfc0000 |=> reject_out && !array_go_out)
        else $error("protected low region was written");
    AST_WEL_CLR: assert property (
        array_go_out |-> !status_out[B_WEL])
        else $error("enable latch still set after start");
    AST_OTP: assert property (
        (status_out[B_LK+:3] & $past(status_out[B_LK+:3])) == $past(status_out[B_LK+:3]))
        else $error("secure area lock bit cleared");
    AST_RSV: assert property (
        status_out[20:19] == 2'h0 && status_out[17:16] == 2'h0)
        else $error("reserved status bit set");
    AST_GLOBAL: assert property (
        cmd_valid_in && cmd_ready_out && cmd_code_in == OP_UNLOCK_ALL && !is_rd_sr ##1 1'b1
        |-> !lk_any)
        else $error("global unlock left a lock set");
    AST_SR_TIME: assert property (
        $rose(st_r.state == ST_SR) |-> status_out[B_WIP] [*8])
        else $error("busy bit short during status write");

    COV_SR_WRITE: cover property ($fell(st_r.state == ST_SR));
    COV_LOCK_REJ: cover property (st_r.state == ST_CHECK && st_r.protect_scheme_select && locked);
    COV_CHIP: cover property (array_go_out && array_op_out == ARR_CHIP);
    COV_LREAD: cover property (st_r.state == ST_LREAD);
endmodule : flp_status_guard

// ### tb/flp_host_model.sv
// Host controller and array engine model facing the status guard.
`timescale 1ns/1ps
module flp_host_model
    import flp_pkg::*;
(
    input wire logic clk_in,
    input wire logic array_go_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_code_out,
    output logic [23:0] cmd_addr_out,
    output logic [7:0] cmd_data_out,
    output logic array_done_out
);
    logic [2:0] busy_r = 3'h0;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 8'h00;
        cmd_addr_out = 24'h000000;
        cmd_data_out = 8'h00;
        array_done_out = 1'b0;
    end
    // Code plus address.
    // Idle fields are scrambled so a stale value can never pass for a fresh one.
    task automatic issue(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_code_out = c;
        cmd_addr_out = a;
        cmd_data_out = d;
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        cmd_code_out = ~c;
        cmd_addr_out = ~a;
        cmd_data_out = ~d;
    endtask : issue
    // The array takes a few cycles, so busy is seen standing.
    always @(posedge clk_in) begin
        array_done_out <= (busy_r == 3'h1);
        if (array_go_in) busy_r <= 3'h4;
        else if (busy_r != 3'h0) busy_r <= busy_r - 3'h1;
    end
endmodule : flp_host_model

// ### tb/flp_status_guard_bench.sv
// Self-checking bench for the flash status guard.
`timescale 1ns/1ps
module flp_status_guard_bench
    import flp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp = 1'b1;
    logic sus_e = 1'b0;
    logic sus_p = 1'b0;
    logic cv, done, rv, rej, go, quad, pfs;
    logic [7:0] cc, cd, rd;
    logic [23:0] ca, st;
    logic [1:0] drv;
    logic rdy;
    flp_arr_t aop;
    logic [23:0] aa;
    int err_total = 0;
    int total_checks = 0;
    logic [4:0] lv [4] = '{5'h01, 5'h09, 5'h11, 5'h19};
    logic [23:0] ok_a [4] = '{24'hfc0000, 24'h03f000, 24'hfff000, 24'h000000};
    logic [23:0] bad_a [4] = '{24'hfbf000, 24'h040000, 24'hffe000, 24'h001000};
    always #20 clk = ~clk;
    flp_host_model host (.clk_in(clk), .array_go_in(go), .cmd_valid_out(cv),
        .cmd_code_out(cc), .cmd_addr_out(ca), .cmd_data_out(cd), .array_done_out(done));
    flp_status_guard dut (.clk_in(clk), .reset_n_in(rst_n), .cmd_valid_in(cv),
        .cmd_code_in(cc), .cmd_addr_in(ca), .cmd_data_in(cd), .write_protect_pin_in(wp),
        .array_done_in(done), .erase_suspended_in(sus_e), .program_suspended_in(sus_p),
        .status_out(st), .rd_data_out(rd), .rd_valid_out(rv), .reject_out(rej),
        .array_go_out(go), .array_op_out(aop), .array_addr_out(aa), .cmd_ready_out(rdy),
        .quad_mode_out(quad), .drive_strength_out(drv), .pin_function_out(pfs));
    task automatic results();
        if (err_total == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d,
        input int lat, input logic g, input logic r);
        host.issue(c, a, d);
        // The issue returns half a cycle after the taking edge, so latency one is checked at once.
        repeat (lat - 1) @(negedge clk);
        chk({go, rej}, {g, r});
    endtask : op
    task automatic wsr(input logic [7:0] c, input logic [7:0] d);
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(c, 24'h0, d, 1, 1'b0, 1'b0);
        chk({rdy, st[1:0]}, 3'h1);
        op(OP_RD_SR0, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        chk({rv, rd[1:0]}, 3'h5);
        repeat (23) @(negedge clk);
        chk({rdy, st[1:0]}, 3'h4);
    endtask : wsr
    task automatic rdlk(input logic [23:0] a, input logic e);
        op(OP_RD_LOCK, a, 8'h0, 2, 1'b0, 1'b0);
        chk({rv, rd}, {1'b1, 7'h0, e});
    endtask : rdlk
    task automatic t_reset();
        chk(st, 24'h400000);
        op(OP_RD_SR2, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        chk({rv, rd}, {1'b1, 8'h40});
        rdlk(24'h000000, 1'b1);
        sus_e = 1'b1;
        sus_p = 1'b1;
        repeat (2) @(negedge clk);
        chk({st[B_ERASE_SUSPENDED_FLAG], st[B_PROGRAM_SUSPENDED_FLAG]}, 2'h3);
        sus_e = 1'b0;
        sus_p = 1'b0;
    endtask : t_reset
    task automatic t_wel();
        op(OP_WR_SR0, 24'h0, 8'h1c, 1, 1'b0, 1'b1);
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_WR_DIS, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_SECT, 24'h0, 8'h0, 1, 1'b0, 1'b1);
        chk(st[7:0], 8'h00);
    endtask : t_wel
    task automatic t_fields();
        wsr(OP_WR_SR2, 8'hff);
        chk({st[23:16], pfs, drv}, {8'he4, 3'h7});
        wsr(OP_WR_SR1, 8'h0a);
        chk({st[15:8], quad}, {8'h0a, 1'b1});
        wsr(OP_WR_SR1, 8'h00);
        chk(st[15:8], 8'h08);
        wsr(OP_WR_SR2, 8'h40);
    endtask : t_fields
    task automatic t_invert();
        wsr(OP_WR_SR1, 8'h40);
        chk(st[B_CMP], 1'b1);
        for (int i = 0; i < 4; i++) begin
            wsr(OP_WR_SR0, {1'b0, lv[i], 2'h0});
            op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
            op(OP_SECT, ok_a[i], 8'h0, 2, 1'b1, 1'b0);
            repeat (8) @(negedge clk);
            op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
            op(OP_SECT, bad_a[i], 8'h0, 2, 1'b0, 1'b1);
        end
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_CHIP_A, 24'h0, 8'h0, 1, 1'b0, 1'b1);
        wsr(OP_WR_SR1, 8'h00);
        wsr(OP_WR_SR0, 8'h60);
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_CHIP_B, 24'h0, 8'h0, 1, 1'b1, 1'b0);
        chk(aa, 24'h000000);
        chk(aop, ARR_CHIP);
        repeat (8) @(negedge clk);
    endtask : t_invert
    task automatic t_locks();
        wsr(OP_WR_SR2, 8'h04);
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_SECT, 24'h000000, 8'h0, 2, 1'b0, 1'b1);
        op(OP_UNLOCK, 24'h010000, 8'h0, 1, 1'b0, 1'b0);
        rdlk(24'h010000, 1'b0);
        rdlk(24'h020000, 1'b1);
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_BLK, 24'h010000, 8'h0, 2, 1'b1, 1'b0);
        chk(aa, 24'h010000);
        chk(aop, ARR_BLK);
        repeat (8) @(negedge clk);
        op(OP_UNLOCK, 24'hff1000, 8'h0, 1, 1'b0, 1'b0);
        rdlk(24'hff1000, 1'b0);
        rdlk(24'hff0000, 1'b1);
        op(OP_LOCK, 24'h010000, 8'h0, 1, 1'b0, 1'b0);
        rdlk(24'h010000, 1'b1);
        op(OP_UNLOCK_ALL, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        rdlk(24'h000000, 1'b0);
        op(OP_LOCK_ALL, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        rdlk(24'hff1000, 1'b1);
        wsr(OP_WR_SR2, 8'h00);
    endtask : t_locks
    task automatic t_guard();
        wp = 1'b0;
        wsr(OP_WR_SR0, 8'h80);
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_WR_SR0, 24'h0, 8'h04, 1, 1'b0, 1'b1);
        wp = 1'b1;
        wsr(OP_WR_SR0, 8'h04);
        wsr(OP_WR_SR1, 8'h01);
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_WR_SR0, 24'h0, 8'h00, 1, 1'b0, 1'b1);
        chk(st[8:2], 7'h41);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(st, 24'h400000);
        wsr(OP_WR_SR0, 8'h80);
        wsr(OP_WR_SR1, 8'h01);
        op(OP_WR_EN, 24'h0, 8'h0, 1, 1'b0, 1'b0);
        op(OP_WR_SR1, 24'h0, 8'h00, 1, 1'b0, 1'b1);
    endtask : t_guard
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_wel();
        t_fields();
        t_invert();
        t_locks();
        t_guard();
        results();
    end
    initial begin
        #400000;
        err_total++;
        results();
    end
endmodule : flp_status_guard_bench
